// ===== rtl/pmcr_pkg.sv
// pmcr_pkg: register map, field positions, reset values and timing counts
// for the misc control register bank.
// assumes a 25 MHz system clock and a byte-wide register port.
package pmcr_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] PMCR_OFS_WD_CFG   = 8'hA0;
    localparam logic [7:0] PMCR_OFS_SERVICE  = 8'hA3;
    localparam logic [7:0] PMCR_OFS_PIN_CTRL = 8'hA4;
    localparam logic [7:0] PMCR_OFS_RST_CTRL = 8'hA5;
    localparam logic [7:0] PMCR_OFS_CSUM_LO  = 8'hB6;
    localparam logic [7:0] PMCR_OFS_CSUM_HI  = 8'hB7;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int         PMCR_PIN_IN_BIT    = 7;
    localparam int         PMCR_PIN_FB_BIT    = 6;
    localparam int         PMCR_PIN_DOUT_BIT  = 4;
    localparam int         PMCR_PIN_DIR_BIT   = 2;
    localparam int         PMCR_RST_FB_BIT    = 6;
    localparam int         PMCR_RST_TRIG_BIT  = 3;
    localparam int         PMCR_CSUM_LO_BIT   = 7;
    localparam logic [7:0] PMCR_SERVICE_CODE  = 8'h2A;
    localparam logic [1:0] PMCR_SRC_INIT      = 2'h0;
    localparam logic [1:0] PMCR_SRC_FAULT     = 2'h1;
    localparam logic [1:0] PMCR_SRC_DIRECT    = 2'h2;
    localparam logic [1:0] PMCR_SRC_SYNC      = 2'h3;
    localparam logic [1:0] PMCR_KICK_FALL     = 2'h0;
    localparam logic [1:0] PMCR_KICK_REG_ONLY = 2'h3;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] PMCR_RST_SERVICE  = 8'h00;
    localparam logic [7:0] PMCR_RST_PIN_CTRL = 8'h00;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int PMCR_CLK_HZ       = 25_000_000;
    localparam int PMCR_PULSE_LONG_MS  = 200;
    localparam int PMCR_PULSE_SHORT_MS = 20;
    localparam int PMCR_PULSE_LONG_CYC  = PMCR_CLK_HZ / 1000 * PMCR_PULSE_LONG_MS;
    localparam int PMCR_PULSE_SHORT_CYC = PMCR_CLK_HZ / 1000 * PMCR_PULSE_SHORT_MS;
    localparam int PMCR_SYNC_HZ      = 2_200_000;
    // sync clock edges per second, spent against the system clock rate
    localparam int PMCR_SYNC_STEP    = 2 * PMCR_SYNC_HZ;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmcr_bus_req_t;

    typedef struct packed {
        logic       o;
        logic       oe_n;
    } pmcr_pin_drv_t;

endpackage : pmcr_pkg

// ===== rtl/pmcr_pulse_timer.sv
// pmcr_pulse_timer: one-shot active-high pulse generator with two selectable lengths.
// assumes trigger is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module pmcr_pulse_timer
#(
    parameter int LONG_CYC  = 5_000_000,
    parameter int SHORT_CYC = 500_000
)
(
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic trigger,
    input  wire logic short_sel,
    output var  logic active
);
    import pmcr_pkg::*;

    localparam int CW = $clog2(LONG_CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          act;
    } pmcr_tmr_st_t;

    pmcr_tmr_st_t st_r;
    pmcr_tmr_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (trigger && !st_r.act)
        begin
            st_nxt.act = 1'b1;
            st_nxt.cnt = short_sel ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
        end
        else if (st_r.act)
        begin
            if (st_r.cnt == '0)
                st_nxt.act = 1'b0;
            else
                st_nxt.cnt = st_r.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign active = st_r.act;

endmodule : pmcr_pulse_timer
`default_nettype wire

// ===== rtl/pmcr_misc_regs.sv
// pmcr_misc_regs: watchdog service, aux pin, reset output and checksum registers.
// assumes a byte-wide register port already decoded from the serial link,
// and all pin inputs synchronous to clk_sys.
// the sync output is paced by a phase accumulator, not an integer divider.
`timescale 1ns/100ps
`default_nettype none

module pmcr_misc_regs
#(
    parameter int PULSE_LONG_CYC  = pmcr_pkg::PMCR_PULSE_LONG_CYC,
    parameter int PULSE_SHORT_CYC = pmcr_pkg::PMCR_PULSE_SHORT_CYC
)
(
    input  wire logic                    clk_sys,
    input  wire logic                    arst_n,
    input  wire pmcr_pkg::pmcr_bus_req_t bus_req,
    output var  logic [7:0]              bus_rdata,
    input  wire logic [1:0]              kick_select,
    input  wire logic                    init_busy,
    input  wire logic                    fault_gpio_active,
    input  wire logic                    short_fault_wait,
    input  wire logic                    checksum_error,
    input  wire logic [8:0]              checksum_value,
    input  wire logic                    aux_pin_i,
    output var  pmcr_pkg::pmcr_pin_drv_t aux_pin_drv,
    output var  logic                    reset_out_n,
    output var  logic                    wd_restart
);
    import pmcr_pkg::*;

    // sync phase accumulator stays below the system clock rate
    localparam int AW = $clog2(PMCR_CLK_HZ);

    typedef struct packed {
        logic [7:0]    service;
        logic          dout;
        logic          dir;
        logic [1:0]    out_sel;
        logic          pin_in_d;
        logic          pin_lvl;
        logic          pin_o;
        logic          pin_oe_n;
        logic          rst_n;
        logic          restart;
        logic          sync_clk;
        logic [AW-1:0] sync_acc;
        logic [7:0]    rdata;
    } pmcr_st_t;

    pmcr_st_t st_r;
    pmcr_st_t st_nxt;
    logic     pulse_active;
    logic     trig;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic bus_hit(input pmcr_bus_req_t r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : bus_hit

    function automatic logic service_valid(input logic [7:0] d);
        return d == PMCR_SERVICE_CODE;
    endfunction : service_valid

    // register restarts per source code; codes 0 to 2 also add a pin edge
    function automatic logic reg_kick_ok(input logic [1:0] sel);
        logic ok;
        ok = 1'b0;
        unique case (sel)
            PMCR_KICK_FALL:     ok = 1'b1;
            PMCR_KICK_REG_ONLY: ok = 1'b1;
            default:            ok = 1'b1;
        endcase
        return ok;
    endfunction : reg_kick_ok

    // pin edge that restarts under a source code
    function automatic logic pin_kick(input logic [1:0] sel, input logic prev, input logic cur);
        logic hit;
        hit = 1'b0;
        if (sel == PMCR_KICK_FALL)
            hit = prev && !cur;
        else if (sel != PMCR_KICK_REG_ONLY)
            hit = !prev && cur;
        return hit;
    endfunction : pin_kick

    // checksum bytes, zero while the fuses are clean
    function automatic logic [7:0] csum_byte(input logic err, input logic [8:0] val, input logic hi);
        logic [7:0] b;
        b = 8'h00;
        if (err && hi)
            b = val[8:1];
        else if (err)
            b[PMCR_CSUM_LO_BIT] = val[0];
        return b;
    endfunction : csum_byte

    // ****************************************************************
    // reset pulse timer
    // ****************************************************************
    // write one fires pulse
    assign trig = bus_hit(bus_req, PMCR_OFS_RST_CTRL) && bus_req.wdata[PMCR_RST_TRIG_BIT];

    // the option is taken at the trigger; a retrigger mid-pulse is dropped
    pmcr_pulse_timer
    #(
        .LONG_CYC  (PULSE_LONG_CYC),
        .SHORT_CYC (PULSE_SHORT_CYC)
    )
    u_pulse
    (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .trigger   (trig),
        .short_sel (short_fault_wait),
        .active    (pulse_active)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic pin_edge;
        logic drive_lvl;
        pin_edge  = 1'b0;
        drive_lvl = 1'b1;
        st_nxt    = st_r;
        st_nxt.restart  = 1'b0;
        st_nxt.pin_in_d = aux_pin_i;

        // ************************************************************
        // pin sampling
        // ************************************************************
        // sample pin level
        st_nxt.pin_lvl = aux_pin_i;

        // ************************************************************
        // register writes
        // ************************************************************
        // reserved bits dropped
        if (bus_hit(bus_req, PMCR_OFS_PIN_CTRL))
        begin
            st_nxt.dout    = bus_req.wdata[PMCR_PIN_DOUT_BIT];
            st_nxt.dir     = bus_req.wdata[PMCR_PIN_DIR_BIT];
            st_nxt.out_sel = bus_req.wdata[1:0];
        end

        // ************************************************************
        // watchdog restart
        // ************************************************************
        // no lock term here, the lock only guards timing registers
        if (bus_hit(bus_req, PMCR_OFS_SERVICE))
        begin
            st_nxt.service = bus_req.wdata;
            if (service_valid(bus_req.wdata) && reg_kick_ok(kick_select))
                st_nxt.restart = 1'b1;
        end

        // pin edge restart sources; only an input kicks
        if (st_r.dir)
            pin_edge = pin_kick(kick_select, st_r.pin_in_d, aux_pin_i);
        if (pin_edge)
            st_nxt.restart = 1'b1;

        // ************************************************************
        // sync clock and pin drive
        // ************************************************************
        // phase accumulator; no integer divider of the system
        // clock gives the sync rate, so edges land on the first cycle at or after the ideal time
        // and the average rate is exact
        if (st_r.sync_acc >= AW'(PMCR_CLK_HZ - PMCR_SYNC_STEP))
        begin
            st_nxt.sync_acc = st_r.sync_acc - AW'(PMCR_CLK_HZ - PMCR_SYNC_STEP);
            st_nxt.sync_clk = !st_r.sync_clk;
        end
        else
            st_nxt.sync_acc = st_r.sync_acc + AW'(PMCR_SYNC_STEP);

        unique case (st_r.out_sel)
            PMCR_SRC_INIT:   drive_lvl = init_busy;
            PMCR_SRC_FAULT:  drive_lvl = !fault_gpio_active;
            PMCR_SRC_DIRECT: drive_lvl = st_r.dout;
            PMCR_SRC_SYNC:   drive_lvl = st_r.sync_clk;
        endcase

        if (st_r.dir)
        begin
            // released pin presents no high level either
            st_nxt.pin_o    = 1'b0;
            st_nxt.pin_oe_n = 1'b1;
        end
        else
        begin
            st_nxt.pin_o    = 1'b0;
            st_nxt.pin_oe_n = drive_lvl;
        end

        // ************************************************************
        // reset output and read mux
        // ************************************************************
        // registered so the pin comes straight from a flip-flop
        st_nxt.rst_n = !pulse_active;

        // read mux; reserved read zero
        st_nxt.rdata = 8'h00;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                PMCR_OFS_SERVICE:
                    st_nxt.rdata = st_r.service;
                PMCR_OFS_PIN_CTRL:
                begin
                    st_nxt.rdata[PMCR_PIN_IN_BIT]   = st_r.dir & st_r.pin_lvl;
                    st_nxt.rdata[PMCR_PIN_FB_BIT]   = !st_r.pin_oe_n;
                    st_nxt.rdata[PMCR_PIN_DOUT_BIT] = st_r.dout;
                    st_nxt.rdata[PMCR_PIN_DIR_BIT]  = st_r.dir;
                    st_nxt.rdata[1:0]               = st_r.out_sel;
                end
                PMCR_OFS_RST_CTRL:
                    st_nxt.rdata[PMCR_RST_FB_BIT] = !st_r.rst_n;
                PMCR_OFS_CSUM_LO:
                    st_nxt.rdata = csum_byte(checksum_error, checksum_value, 1'b0);
                PMCR_OFS_CSUM_HI:
                    st_nxt.rdata = csum_byte(checksum_error, checksum_value, 1'b1);
                default:
                    st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r.service  <= PMCR_RST_SERVICE;
            st_r.dout     <= PMCR_RST_PIN_CTRL[PMCR_PIN_DOUT_BIT];
            st_r.dir      <= PMCR_RST_PIN_CTRL[PMCR_PIN_DIR_BIT];
            st_r.out_sel  <= PMCR_RST_PIN_CTRL[1:0];
            // pin history starts at the released level, no false edge
            st_r.pin_in_d <= 1'b1;
            st_r.pin_lvl  <= 1'b0;
            st_r.pin_o    <= 1'b0;
            st_r.pin_oe_n <= 1'b1;
            st_r.rst_n    <= 1'b1;
            st_r.restart  <= 1'b0;
            st_r.sync_clk <= 1'b0;
            st_r.sync_acc <= '0;
            st_r.rdata    <= 8'h00;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign bus_rdata        = st_r.rdata;
    assign aux_pin_drv.o    = st_r.pin_o;
    assign aux_pin_drv.oe_n = st_r.pin_oe_n;
    assign reset_out_n      = st_r.rst_n;
    assign wd_restart       = st_r.restart;

endmodule : pmcr_misc_regs
`default_nettype wire

// ===== testbench/pmcr_host_model.sv
// pmcr_host_model: host side of the byte register port.
// assumes the bench calls wr_reg and rd_reg one at a time.
`timescale 1ns/100ps
`default_nettype none
module pmcr_host_model
(
    input  wire logic                    clk_sys,
    output var  pmcr_pkg::pmcr_bus_req_t bus_req,
    input  wire logic [7:0]              bus_rdata
);
    import pmcr_pkg::*;
    // ****
    // one-cycle strobes; a released bus shows inverted values
    // ****
    initial bus_req = '0;
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        bus_req <= '{1'b0, 1'b0, ~a, 8'hFF};
        // data stands for the cycle after the read edge; take it at its end
        @(posedge clk_sys);
        d = bus_rdata;
    endtask : rd_reg
endmodule : pmcr_host_model
`default_nettype wire

// ===== testbench/pmcr_misc_regs_monitor.sv
// pmcr_misc_regs_monitor: port assertions for the misc register bank.
// assumes it is bound into pmcr_misc_regs.
`timescale 1ns/100ps
`default_nettype none
module pmcr_misc_regs_monitor
#(
    parameter int PULSE_LONG_CYC  = 20,
    parameter int PULSE_SHORT_CYC = 5
)
(
    input wire logic                    clk_sys,
    input wire logic                    arst_n,
    input wire pmcr_pkg::pmcr_bus_req_t bus_req,
    input wire logic [7:0]              bus_rdata,
    input wire logic                    short_fault_wait,
    input wire logic                    checksum_error,
    input wire logic [8:0]              checksum_value,
    input wire pmcr_pkg::pmcr_pin_drv_t aux_pin_drv,
    input wire logic                    reset_out_n,
    input wire logic                    wd_restart
);
    import pmcr_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ****
    // pulse length counter
    // ****
    int   low_cnt;
    logic short_q;
    wire  trig  = bus_req.wr && bus_req.addr == PMCR_OFS_RST_CTRL && bus_req.wdata[PMCR_RST_TRIG_BIT];
    wire  rd_lo = bus_req.rd && bus_req.addr == PMCR_OFS_CSUM_LO;
    wire  rd_hi = bus_req.rd && bus_req.addr == PMCR_OFS_CSUM_HI;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt <= 0;
            short_q <= 1'b0;
        end
        else
        begin
            low_cnt <= reset_out_n ? 0 : low_cnt + 1;
            if ($fell(reset_out_n))
                short_q <= $past(short_fault_wait, 2);
        end
    end
    AST_KICK_CODE: assert property (bus_req.wr && bus_req.addr == PMCR_OFS_SERVICE
        && bus_req.wdata == PMCR_SERVICE_CODE |=> wd_restart) else $error("no restart after code");
    AST_CSUM_CLEAN: assert property ((rd_lo || rd_hi) && !checksum_error |=> bus_rdata == 8'h00)
        else $error("checksum not zero");
    AST_CSUM_LO: assert property (rd_lo && checksum_error |=>
        bus_rdata == {$past(checksum_value[0]), 7'h00}) else $error("low checksum wrong");
    AST_CSUM_HI: assert property (rd_hi && checksum_error |=>
        bus_rdata == $past(checksum_value[8:1])) else $error("high checksum wrong");
    AST_UNMAPPED: assert property (bus_req.rd && !(bus_req.addr inside {8'hA3, 8'hA4, 8'hA5,
        8'hB6, 8'hB7}) |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
    AST_OPEN_DRAIN: assert property (aux_pin_drv.o == 1'b0) else $error("pin driven high");
    AST_PIN_FB: assert property (bus_req.rd && bus_req.addr == PMCR_OFS_PIN_CTRL |=>
        bus_rdata[6] == !$past(aux_pin_drv.oe_n) && bus_rdata[5] == 1'b0 && bus_rdata[3] == 1'b0)
        else $error("pin feedback wrong");
    AST_RST_CAUSE: assert property ($fell(reset_out_n) |-> $past(trig, 2))
        else $error("reset pulse without trigger");
    AST_RST_LEN: assert property ($rose(reset_out_n) |->
        low_cnt == (short_q ? PULSE_SHORT_CYC : PULSE_LONG_CYC)) else $error("reset pulse length");
    AST_RST_FB: assert property (bus_req.rd && bus_req.addr == PMCR_OFS_RST_CTRL |=>
        bus_rdata == {1'b0, !$past(reset_out_n), 6'h00}) else $error("reset feedback wrong");
    COV_PULSE: cover property ($fell(reset_out_n));
    COV_KICK: cover property (wd_restart);
    COV_SYNC: cover property ($changed(aux_pin_drv.oe_n));
endmodule : pmcr_misc_regs_monitor
bind pmcr_misc_regs pmcr_misc_regs_monitor #(.PULSE_LONG_CYC(PULSE_LONG_CYC), .PULSE_SHORT_CYC(PULSE_SHORT_CYC))
    pmcr_misc_regs_monitor_inst (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .short_fault_wait(short_fault_wait), .checksum_error(checksum_error), .checksum_value(checksum_value),
    .aux_pin_drv(aux_pin_drv), .reset_out_n(reset_out_n), .wd_restart(wd_restart));
`default_nettype wire

// ===== testbench/tb.sv
// tb: self-checking bench for the misc register bank.
// assumes short pulse counts and one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pmcr_pkg::*;
    localparam int LONG_C = 20;
    localparam int SHORT_C = 5;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] kick_select = 2'h0;
    logic init_busy = 1'b0, fault_gpio_active = 1'b0, short_fault_wait = 1'b0, checksum_error = 1'b0;
    logic [8:0] checksum_value = 9'h000;
    logic pin_ext = 1'b1;
    logic [7:0] bus_rdata;
    logic reset_out_n, wd_restart;
    pmcr_bus_req_t bus_req;
    pmcr_pin_drv_t aux_pin_drv;
    int bad_count = 0, checks = 0, cyc = 0, kicks = 0, seed = 5;
    // wire level: open drain pulls low, else the outside level
    wire logic aux_pin_i = aux_pin_drv.oe_n ? pin_ext : 1'b0;
    pmcr_host_model pmcr_host_model_inst (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));
    pmcr_misc_regs #(.PULSE_LONG_CYC(LONG_C), .PULSE_SHORT_CYC(SHORT_C)) pmcr_misc_regs_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .kick_select(kick_select), .init_busy(init_busy), .fault_gpio_active(fault_gpio_active),
        .short_fault_wait(short_fault_wait), .checksum_error(checksum_error),
        .checksum_value(checksum_value), .aux_pin_i(aux_pin_i), .aux_pin_drv(aux_pin_drv),
        .reset_out_n(reset_out_n), .wd_restart(wd_restart));
    // ****
    // clock, timeout, restart counter
    // ****
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        kicks <= kicks + int'(wd_restart === 1'b1);
        if (cyc == 5000)
        begin
            bad_count++;
            test_done();
        end
    end
    function automatic logic [7:0] f_pin(logic [7:0] w, logic ib, logic flt, logic pin);
        logic oe_n;
        oe_n = w[2] | (w[1:0] == 2'h0 ? ib : w[1:0] == 2'h1 ? ~flt : w[4]);
        return {w[2] & pin, ~oe_n, 1'b0, w[4], 1'b0, w[2], w[1:0]};
    endfunction : f_pin
    function automatic logic [7:0] f_cs(logic err, logic [8:0] v, logic hi);
        return !err ? 8'h00 : hi ? v[8:1] : {v[0], 7'h00};
    endfunction : f_cs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        pmcr_host_model_inst.rd_reg(a, d);
        chk(d, exp);
    endtask : rd_chk
    task automatic test_done();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    // ****
    // main sequence
    // ****
    initial
    begin
        logic [7:0] d, e;
        int k0, t;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(PMCR_OFS_SERVICE, 8'h00);
        rd_chk(PMCR_OFS_RST_CTRL, 8'h00);
        rd_chk(PMCR_OFS_PIN_CTRL, f_pin(8'h00, 1'b0, 1'b0, 1'b1));
        pmcr_host_model_inst.wr_reg(PMCR_OFS_PIN_CTRL, 8'h04);
        for (int ks = 0; ks < 4; ks++)
        begin
            kick_select <= ks[1:0];
            pin_ext <= (ks == 0);
            repeat (4) @(posedge clk_sys);
            k0 = kicks;
            pin_ext <= (ks != 0);
            repeat (4) @(posedge clk_sys);
            chk(8'(kicks - k0), (ks == 3) ? 8'h00 : 8'h01);
            rd_chk(PMCR_OFS_PIN_CTRL, f_pin(8'h04, init_busy, fault_gpio_active, pin_ext));
            d = ks[0] ? 8'($random(seed)) : PMCR_SERVICE_CODE;
            k0 = kicks;
            pmcr_host_model_inst.wr_reg(PMCR_OFS_SERVICE, d);
            repeat (2) @(posedge clk_sys);
            chk(8'(kicks - k0), {7'h00, d == PMCR_SERVICE_CODE});
            rd_chk(PMCR_OFS_SERVICE, d);
        end
        for (int i = 0; i < 12; i++)
        begin
            d = 8'($random(seed));
            if (!d[2] && d[1:0] == PMCR_SRC_SYNC)
                d[1:0] = PMCR_SRC_DIRECT;
            init_busy <= 1'($random(seed));
            fault_gpio_active <= 1'($random(seed));
            pin_ext <= 1'($random(seed));
            pmcr_host_model_inst.wr_reg(PMCR_OFS_PIN_CTRL, d);
            repeat (3) @(posedge clk_sys);
            e = f_pin(d, init_busy, fault_gpio_active, pin_ext);
            chk({7'h00, aux_pin_drv.oe_n}, {7'h00, ~e[6]});
            rd_chk(PMCR_OFS_PIN_CTRL, e);
        end
        pmcr_host_model_inst.wr_reg(PMCR_OFS_PIN_CTRL, {6'h00, PMCR_SRC_SYNC});
        repeat (3) @(posedge clk_sys);
        t = 0;
        repeat (125)
        begin
            d[0] = aux_pin_drv.oe_n;
            @(posedge clk_sys);
            t += int'(aux_pin_drv.oe_n !== d[0]);
        end
        chk(8'(t), 8'(125 * PMCR_SYNC_STEP / PMCR_CLK_HZ));
        for (int i = 0; i < 2; i++)
        begin
            short_fault_wait <= i[0];
            t = 0;
            d = 8'($random(seed)) | 8'h08;
            fork
                repeat (40)
                begin
                    @(posedge clk_sys);
                    t += (reset_out_n === 1'b0);
                end
                begin
                    pmcr_host_model_inst.wr_reg(PMCR_OFS_RST_CTRL, d);
                    pmcr_host_model_inst.wr_reg(PMCR_OFS_RST_CTRL, 8'h08);
                    rd_chk(PMCR_OFS_RST_CTRL, 8'h40);
                end
            join
            chk(8'(t), 8'(i ? SHORT_C : LONG_C));
        end
        for (int i = 0; i < 6; i++)
        begin
            checksum_error <= i[0];
            checksum_value <= 9'($random(seed));
            @(posedge clk_sys);
            rd_chk(PMCR_OFS_CSUM_LO, f_cs(checksum_error, checksum_value, 1'b0));
            rd_chk(PMCR_OFS_CSUM_HI, f_cs(checksum_error, checksum_value, 1'b1));
        end
        rd_chk(PMCR_OFS_WD_CFG, 8'h00);
        rd_chk(8'hA6, 8'h00);
        test_done();
    end
endmodule : tb
`default_nettype wire
